//--- rtc_aux_out.sv
// square-wave, fixed 32k, static output and oscillator-fail logic
// assumes osc_running comes from the oscillator domain, wdog_irq from
// the watchdog block on clk, and software on the plain register port
//
// Behaviour
// - frequency select is four bits in register 04h
// - code 0 off, 1 gives 32.768 kHz, 2 gives 8.192 kHz, then halving
// - square wave toggles only while its enable in 0Ah is set; push-pull pin is driven low while clear
// - power-up 32 kHz enabled; open-drain variant powers up disabled
// - fixed 32k pin on at power-up, stops on enable clear or halt
// - century bits count in binary at century rollover
// - leap year if divisible by four; century years only when bits 00
// - without interrupt sources the irq pin follows the static-level bit
// - static mode pulls pin low for 0, releases for 1
// - fail flag sets whenever the oscillator stops
// - fail flag reads one after first power
// - fail flag stays set until software writes zero
// - fail interrupt clears only by writing enable or flag zero; at irq its status bit clears on a read of 10h instead
// - power-on values of halt, flag, enables, static and test bits
// - calibration never changes square-wave or test output frequency
`timescale 1ns/1ps
module rtc_aux_out
    import rtc_aux_pkg::*;
#(
    parameter bit OPEN_DRAIN_SQW = 1'b0
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       reset_n,
    // register port
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr_en,
    input  wire logic       rd_en,
    output logic [7:0]      rdata,
    // oscillator and neighbours
    input  wire logic       osc_running,
    input  wire logic       alarm_flag,
    input  wire logic       wdog_irq,
    input  wire logic       year_rollover,
    input  wire logic [7:0] year_bcd,
    output logic            leap_year,
    // pins
    output logic            square_wave_pin,
    output logic            square_wave_oe,
    output logic            fixed_32k_pin,
    output logic            irq_out_o,
    output logic            irq_out_oe,
    // interrupt
    output logic            irq
);
    // ********************************
    // registers
    // ********************************
    logic [3:0] sqw_freq_select_q, sqw_freq_select_d;
    logic       sqw_out_enable_q, sqw_out_enable_d;
    logic       alarm_irq_enable_q, alarm_irq_enable_d;
    logic       static_level_q, static_level_d;
    logic       freq_test_bit_q, freq_test_bit_d;
    logic [5:0] calib_q, calib_d;
    logic       osc_halt_bit_q, osc_halt_bit_d;
    logic       fixed_32k_enable_q, fixed_32k_enable_d;
    logic       osc_fail_irq_enable_q, osc_fail_irq_enable_d;
    logic       wdog_enable_q, wdog_enable_d;
    logic       osc_fail_flag_q, osc_fail_flag_d;
    logic [1:0] irq_stat_q, irq_stat_d;
    logic [1:0] irq_mask_q, irq_mask_d;
    logic [7:0] rdata_q, rdata_d;
    logic       sqw_q, sqw_d;
    logic       fixed_32k_pin_q, fixed_32k_pin_d;
    logic       osc_meta_q, osc_sync_q, osc_prev_q;
    // half-period count needs room for the full system-cycle count
    localparam int TICK_BITS = $clog2(OSC_HALF_CYC);
    logic [TICK_BITS-1:0] tick_cnt_q, tick_cnt_d;
    logic       osc_tick;
    logic [DIV_BITS-1:0] taps;
    logic [1:0] century_q;
    logic       stop_event;
    logic       of_irq;
    logic       irq_source;

    // decode one register address
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_a);
        hit = (a == ref_a);
    endfunction

    // ********************************
    // oscillator sync and divider
    // ********************************
    // two-stage sync of the oscillator running status
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            osc_meta_q <= 1'b0;
            osc_sync_q <= 1'b0;
            osc_prev_q <= 1'b0;
        end else begin
            osc_meta_q <= osc_running;
            osc_sync_q <= osc_meta_q;
            osc_prev_q <= osc_sync_q;
        end
    end

    // stop seen as loss of running or halt set
    assign stop_event = (osc_prev_q && !osc_sync_q) || osc_halt_bit_q;

    // half-period tick of the oscillator, independent of calibration
    always_comb begin
        tick_cnt_d = tick_cnt_q + 1'b1;
        osc_tick   = 1'b0;
        if (tick_cnt_q == TICK_BITS'(OSC_HALF_CYC - 1)) begin
            tick_cnt_d = '0;
            osc_tick   = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            tick_cnt_q <= '0;
        end else begin
            tick_cnt_q <= tick_cnt_d;
        end
    end

    rtc_clock_div #(.WIDTH(DIV_BITS)) u_div (
        .clk      (clk),
        .reset_n  (reset_n),
        .run      (osc_sync_q && !osc_halt_bit_q),
        .osc_tick (osc_tick),
        .taps     (taps)
    );

    rtc_century u_century (
        .clk           (clk),
        .reset_n       (reset_n),
        .year_rollover (year_rollover),
        .year_bcd      (year_bcd),
        .cb_wr         (wr_en && hit(addr, ADDR_CENTURY)),
        .cb_wdata      (wdata[CB_LSB+1:CB_LSB]),
        .century_q     (century_q),
        .leap_year     (leap_year)
    );

    // ********************************
    // register writes and flags
    // ********************************
    always_comb begin
        sqw_freq_select_d     = sqw_freq_select_q;
        sqw_out_enable_d      = sqw_out_enable_q;
        alarm_irq_enable_d    = alarm_irq_enable_q;
        static_level_d        = static_level_q;
        freq_test_bit_d       = freq_test_bit_q;
        calib_d               = calib_q;
        osc_halt_bit_d        = osc_halt_bit_q;
        fixed_32k_enable_d    = fixed_32k_enable_q;
        osc_fail_irq_enable_d = osc_fail_irq_enable_q;
        wdog_enable_d         = wdog_enable_q;
        osc_fail_flag_d       = osc_fail_flag_q;
        irq_mask_d            = irq_mask_q;
        irq_stat_d            = irq_stat_q;
        if (wr_en) begin
            if (hit(addr, ADDR_SQW_SEL)) begin
                sqw_freq_select_d = wdata[SEL_LSB+3:SEL_LSB];
            end
            if (hit(addr, ADDR_SQW_CTL)) begin
                sqw_out_enable_d   = wdata[SQW_OUT_ENABLE_BIT];
                alarm_irq_enable_d = wdata[AFE_BIT];
            end
            if (hit(addr, ADDR_CALIB)) begin
                static_level_d  = wdata[OUT_BIT];
                freq_test_bit_d = wdata[FT_BIT];
                calib_d         = wdata[5:0];
            end
            if (hit(addr, ADDR_CTRL)) begin
                osc_halt_bit_d        = wdata[HALT_BIT];
                fixed_32k_enable_d    = wdata[F32KE_BIT];
                osc_fail_irq_enable_d = wdata[OSC_FAIL_IRQ_ENABLE_BIT];
                wdog_enable_d         = wdata[WDOG_BIT];
            end
            // only a written zero clears; a one is ignored
            if (hit(addr, ADDR_FLAGS) && !wdata[OF_BIT]) begin
                osc_fail_flag_d = 1'b0;
            end
            if (hit(addr, ADDR_IRQ_MASK)) begin
                irq_mask_d = wdata[1:0];
            end
        end
        // reading the status clears it
        if (rd_en && hit(addr, ADDR_IRQ_STAT)) begin
            irq_stat_d = 2'b00;
        end
        // set wins over any clear in the same cycle
        if (stop_event) begin
            osc_fail_flag_d = 1'b1;
            irq_stat_d[0]   = 1'b1;
        end
        if (alarm_flag) begin
            irq_stat_d[1] = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sqw_freq_select_q     <= RST_SEL;
            sqw_out_enable_q      <= OPEN_DRAIN_SQW ? RST_ZERO : RST_ONE;
            alarm_irq_enable_q    <= RST_ZERO;
            static_level_q        <= RST_ONE;
            freq_test_bit_q       <= RST_ZERO;
            calib_q               <= 6'h00;
            osc_halt_bit_q        <= RST_ZERO;
            fixed_32k_enable_q    <= RST_ONE;
            osc_fail_irq_enable_q <= RST_ZERO;
            wdog_enable_q         <= RST_ZERO;
            osc_fail_flag_q       <= RST_ONE;
            irq_mask_q            <= 2'b00;
            irq_stat_q            <= 2'b00;
        end else begin
            sqw_freq_select_q     <= sqw_freq_select_d;
            sqw_out_enable_q      <= sqw_out_enable_d;
            alarm_irq_enable_q    <= alarm_irq_enable_d;
            static_level_q        <= static_level_d;
            freq_test_bit_q       <= freq_test_bit_d;
            calib_q               <= calib_d;
            osc_halt_bit_q        <= osc_halt_bit_d;
            fixed_32k_enable_q    <= fixed_32k_enable_d;
            osc_fail_irq_enable_q <= osc_fail_irq_enable_d;
            wdog_enable_q         <= wdog_enable_d;
            osc_fail_flag_q       <= osc_fail_flag_d;
            irq_mask_q            <= irq_mask_d;
            irq_stat_q            <= irq_stat_d;
        end
    end

    // ********************************
    // outputs and read data
    // ********************************
    // tap for code n: code 1 raw osc, code 2 div4, then one more per code
    always_comb begin
        sqw_d = 1'b0;
        case (sqw_freq_select_q)
            4'h0: sqw_d = 1'b0;
            4'h1: sqw_d = taps[0];
            4'hF: sqw_d = taps[15];
            default: sqw_d = taps[sqw_freq_select_q];
        endcase
        if (!sqw_out_enable_q) begin
            sqw_d = 1'b0;
        end
        fixed_32k_pin_d = taps[0] && fixed_32k_enable_q && !osc_halt_bit_q;
        rdata_d = 8'h00;
        if (rd_en) begin
            if (hit(addr, ADDR_SQW_SEL)) rdata_d = {sqw_freq_select_q, 4'h0};
            if (hit(addr, ADDR_SQW_CTL)) rdata_d = {alarm_irq_enable_q, sqw_out_enable_q, 6'h00};
            if (hit(addr, ADDR_CALIB)) rdata_d = {static_level_q, freq_test_bit_q, calib_q};
            if (hit(addr, ADDR_CTRL)) rdata_d = {osc_halt_bit_q, fixed_32k_enable_q,
                                                 osc_fail_irq_enable_q, wdog_enable_q, 4'h0};
            if (hit(addr, ADDR_FLAGS)) rdata_d = {5'h00, osc_fail_flag_q, 2'b00};
            if (hit(addr, ADDR_CENTURY)) rdata_d = {century_q, 6'h00};
            if (hit(addr, ADDR_IRQ_STAT)) rdata_d = {6'h00, irq_stat_q};
            if (hit(addr, ADDR_IRQ_MASK)) rdata_d = {6'h00, irq_mask_q};
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sqw_q   <= 1'b0;
            fixed_32k_pin_q  <= 1'b0;
            rdata_q <= 8'h00;
        end else begin
            sqw_q   <= sqw_d;
            fixed_32k_pin_q  <= fixed_32k_pin_d;
            rdata_q <= rdata_d;
        end
    end

    // irq/out pin: interrupt mode if any source enabled, else static level
    assign of_irq     = osc_fail_irq_enable_q && osc_fail_flag_q;
    assign irq_source = osc_fail_irq_enable_q || alarm_irq_enable_q || wdog_enable_q;
    assign irq_out_o  = 1'b0;
    assign irq_out_oe = irq_source ? (of_irq || (alarm_irq_enable_q && alarm_flag) || wdog_irq)
                                   : !static_level_q;
    assign square_wave_pin = OPEN_DRAIN_SQW ? 1'b0 : sqw_q;
    assign square_wave_oe  = OPEN_DRAIN_SQW ? (sqw_out_enable_q && !sqw_q) : 1'b1;
    assign fixed_32k_pin   = fixed_32k_pin_q;
    assign rdata           = rdata_q;
    assign irq             = |(irq_stat_q & irq_mask_q);

    // ********************************
    // checks
    // ********************************
    sqw_off_a: assert property (@(posedge clk) disable iff (!reset_n)
        !sqw_out_enable_q |=> !sqw_q)
        else $error("square wave active while disabled");
    sel_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
        sqw_freq_select_q == 4'h0 |=> !sqw_q)
        else $error("code zero produced output");
    fixed_32k_pin_stop_a: assert property (@(posedge clk) disable iff (!reset_n)
        (osc_halt_bit_q || !fixed_32k_enable_q) |=> !fixed_32k_pin)
        else $error("fixed 32k toggled while stopped");
    of_set_a: assert property (@(posedge clk) disable iff (!reset_n)
        stop_event |=> osc_fail_flag_q)
        else $error("fail flag missed a stop");
    of_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
        (osc_fail_flag_q && !(wr_en && hit(addr, ADDR_FLAGS) && !wdata[OF_BIT]))
        |=> osc_fail_flag_q)
        else $error("fail flag dropped without write");
    of_irq_a: assert property (@(posedge clk) disable iff (!reset_n)
        of_irq |-> irq_out_oe)
        else $error("fail interrupt not on pin");
    static_a: assert property (@(posedge clk) disable iff (!reset_n)
        !irq_source |-> (irq_out_oe == !static_level_q))
        else $error("static output mismatch");
    calib_a: assert property (@(posedge clk) disable iff (!reset_n)
        $changed(calib_q) |-> $stable(sqw_freq_select_q))
        else $error("calibration moved square wave select");
endmodule

//--- rtc_aux_out_tb.sv
// self-checking bench for the rtc auxiliary output and oscillator-fail logic
// assumes the plain register port and a 100 MHz clock
`timescale 1ns/1ps
module rtc_aux_out_tb;
    import rtc_aux_pkg::*;
    logic       clk, reset_n, wr_en, rd_en, osc_on, alarm_flag, wdog_irq, year_rollover;
    logic [7:0] addr, wdata, rdata, rdata_od, year_bcd, rv;
    logic       leap_year, square_wave_pin, square_wave_oe, fixed_32k_pin, sqw_oe_od;
    logic       irq_out_o, irq_out_oe, irq, osc_running, irq_line;
    int         fails, checks, h1, hn, tg;

    // ********************************
    // instances
    // ********************************
    rtc_aux_out #(.OPEN_DRAIN_SQW(1'b0)) DUT (.clk, .reset_n, .addr, .wdata, .wr_en,
        .rd_en, .rdata, .osc_running, .alarm_flag, .wdog_irq, .year_rollover, .year_bcd,
        .leap_year, .square_wave_pin, .square_wave_oe, .fixed_32k_pin, .irq_out_o,
        .irq_out_oe, .irq);
    rtc_aux_out #(.OPEN_DRAIN_SQW(1'b1)) DUT_OD (.clk, .reset_n, .addr, .wdata, .wr_en,
        .rd_en, .rdata(rdata_od), .osc_running, .alarm_flag, .wdog_irq, .year_rollover,
        .year_bcd, .leap_year(), .square_wave_pin(), .square_wave_oe(sqw_oe_od), .fixed_32k_pin(),
        .irq_out_o(), .irq_out_oe(), .irq());
    rtc_board board (.osc_on, .irq_out_o, .irq_out_oe, .osc_running, .irq_line);

    // ********************************
    // shared tasks
    // ********************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        d = rdata;
    endtask
    // cycles until the watched pin changes, capped at lim
    task automatic edge_wait(input bit fixed, input int lim, output int n);
        logic s;
        @(negedge clk);
        s = fixed ? fixed_32k_pin : square_wave_pin;
        n = 0;
        while (n < lim && (fixed ? fixed_32k_pin : square_wave_pin) === s) begin
            @(negedge clk);
            n++;
        end
    endtask
    task automatic settle;
        repeat (4) @(negedge clk);
    endtask

    // ********************************
    // scenarios
    // ********************************
    task automatic t_reset;
        rd(ADDR_SQW_SEL, rv);
        chk(rv[7:4], RST_SEL);
        rd(ADDR_SQW_CTL, rv);
        chk({rv[AFE_BIT], rv[SQW_OUT_ENABLE_BIT], rdata_od[SQW_OUT_ENABLE_BIT]}, 3'b010);
        rd(ADDR_CALIB, rv);
        chk({rv[OUT_BIT], rv[FT_BIT]}, 2'b10);
        rd(ADDR_CTRL, rv);
        chk({rv[HALT_BIT], rv[F32KE_BIT], rv[OSC_FAIL_IRQ_ENABLE_BIT], rv[WDOG_BIT]}, 4'b0100);
        rd(ADDR_FLAGS, rv);
        chk(rv[OF_BIT], 1'b1);
        rd(8'h3C, rv);
        chk(rv, 8'h00);
        chk(irq_line, 1'b1);
        chk({square_wave_oe, sqw_oe_od}, 2'b10);
    endtask
    task automatic t_sqw;
        edge_wait(0, 4000, tg);
        edge_wait(0, 4000, h1);
        chk(h1 >= 1524 && h1 <= 1528, 1);
        wr(ADDR_CALIB, 8'h9F); // keep static level high, calibration field at 1Fh (maximum is 3Fh)
        edge_wait(0, 4000, tg);
        edge_wait(0, 4000, hn);
        chk(hn, h1);
        for (int c = 2; c <= 3; c++) begin
            wr(ADDR_SQW_SEL, {c[3:0], 4'h0});
            settle;
            edge_wait(0, 16000, tg);
            edge_wait(0, 16000, hn);
            chk(hn >= (h1 << c) - 8 && hn <= (h1 << c) + 8, 1);
        end
        wr(ADDR_SQW_SEL, 8'h00);
        settle;
        edge_wait(0, 4000, tg);
        chk(tg, 4000);
        wr(ADDR_SQW_SEL, 8'h10);
        wr(ADDR_SQW_CTL, 8'h00);
        settle;
        edge_wait(0, 4000, tg);
        chk(tg, 4000);
        wr(ADDR_SQW_CTL, 8'h40);
        edge_wait(0, 4000, tg);
        chk(tg < 4000, 1);
    endtask
    task automatic t_fixed_32k_pin;
        edge_wait(1, 4000, tg);
        chk(tg < 4000, 1);
        wr(ADDR_CTRL, 8'h00);
        settle;
        edge_wait(1, 4000, tg);
        chk(tg, 4000);
        wr(ADDR_FLAGS, 8'h00);
        rd(ADDR_FLAGS, rv);
        chk(rv[OF_BIT], 1'b0);
        wr(ADDR_CTRL, 8'hC0);
        settle;
        edge_wait(1, 4000, tg);
        chk(tg, 4000);
        rd(ADDR_FLAGS, rv);
        chk(rv[OF_BIT], 1'b1);
        wr(ADDR_CTRL, 8'h40);
        edge_wait(1, 4000, tg);
        chk(tg < 4000, 1);
        wr(ADDR_FLAGS, 8'h00);
        rd(ADDR_FLAGS, rv);
        chk(rv[OF_BIT], 1'b0);
        wr(ADDR_FLAGS, 8'h04);
        rd(ADDR_FLAGS, rv);
        chk(rv[OF_BIT], 1'b0);
    endtask
    task automatic t_fail;
        wr(ADDR_CTRL, 8'h60);
        settle;
        chk(irq_line, 1'b1);
        @(posedge clk);
        osc_on <= 1'b0;
        repeat (8) @(posedge clk);
        rd(ADDR_FLAGS, rv);
        chk(rv[OF_BIT], 1'b1);
        settle;
        chk(irq_line, 1'b0);
        @(posedge clk);
        osc_on <= 1'b1;
        wr(ADDR_CTRL, 8'h40);
        settle;
        chk(irq_line, 1'b1);
        wr(ADDR_CTRL, 8'h60);
        settle;
        chk(irq_line, 1'b0);
        wr(ADDR_FLAGS, 8'h00);
        settle;
        chk(irq_line, 1'b1);
        wr(ADDR_CTRL, 8'h40);
        wr(ADDR_CALIB, 8'h1F);
        settle;
        chk(irq_line, 1'b0);
        wr(ADDR_CALIB, 8'h9F);
        settle;
        chk(irq_line, 1'b1);
    endtask
    task automatic t_stat;
        wr(ADDR_IRQ_MASK, 8'h02);
        settle;
        chk(irq, 1'b0);
        rd(ADDR_IRQ_STAT, rv);
        @(posedge clk);
        alarm_flag <= 1'b1;
        @(posedge clk);
        alarm_flag <= 1'b0;
        settle;
        chk(irq, 1'b1);
        rd(ADDR_IRQ_STAT, rv);
        chk(rv[1:0], 2'b10);
        settle;
        chk(irq, 1'b0);
        wr(ADDR_IRQ_MASK, 8'h00);
        @(posedge clk);
        alarm_flag <= 1'b1;
        @(posedge clk);
        alarm_flag <= 1'b0;
        settle;
        chk(irq, 1'b0);
        wr(ADDR_IRQ_MASK, 8'h02);
        settle;
        chk(irq, 1'b1);
        rd(ADDR_IRQ_STAT, rv);
    endtask
    task automatic leap(input logic [1:0] cb, input logic [7:0] y, input logic e);
        wr(ADDR_CENTURY, {cb, 6'h00});
        year_bcd <= y;
        settle;
        chk(leap_year, e);
    endtask
    task automatic roll(input logic [1:0] e);
        @(posedge clk);
        year_rollover <= 1'b1;
        @(posedge clk);
        year_rollover <= 1'b0;
        rd(ADDR_CENTURY, rv);
        chk(rv[7:6], e);
    endtask
    task automatic t_century;
        leap(2'b00, 8'h00, 1'b1);
        leap(2'b01, 8'h00, 1'b0);
        leap(2'b11, 8'h04, 1'b1);
        leap(2'b10, 8'h01, 1'b0);
        leap(2'b00, 8'h96, 1'b1);
        roll(2'b01);
        roll(2'b10);
        wr(ADDR_CENTURY, 8'hC0);
        roll(2'b00);
    endtask
    task automatic summarize;
        if (fails == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ********************************
    // clock, sequence and watchdog
    // ********************************
    always #5 clk = ~clk;
    initial begin
        clk = 0;
        reset_n = 0;
        addr = 0;
        wdata = 0;
        wr_en = 0;
        rd_en = 0;
        osc_on = 1;
        alarm_flag = 0;
        wdog_irq = 0;
        year_rollover = 0;
        year_bcd = 0;
        fails = 0;
        checks = 0;
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        t_reset;
        t_sqw;
        t_fixed_32k_pin;
        t_fail;
        t_stat;
        t_century;
        summarize;
    end
    initial begin
        repeat (90000) @(posedge clk);
        fails++;
        summarize;
    end
endmodule

//--- rtc_aux_pkg.sv
// constants shared by the rtc auxiliary output and oscillator-fail logic
// assumes a 100 MHz system clock and a plain register port
package rtc_aux_pkg;

    // ********************************
    // register offsets
    // ********************************
    localparam logic [7:0] ADDR_SQW_SEL  = 8'h04;
    localparam logic [7:0] ADDR_SQW_CTL  = 8'h0A;
    localparam logic [7:0] ADDR_CALIB    = 8'h08;
    localparam logic [7:0] ADDR_CTRL     = 8'h01;
    localparam logic [7:0] ADDR_FLAGS    = 8'h0F;
    localparam logic [7:0] ADDR_CENTURY  = 8'h07;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h11;

    // ********************************
    // field positions
    // ********************************
    localparam int SEL_LSB       = 4;
    localparam int SQW_OUT_ENABLE_BIT      = 6;
    localparam int AFE_BIT       = 7;
    localparam int OUT_BIT       = 7;
    localparam int FT_BIT        = 6;
    localparam int HALT_BIT      = 7;
    localparam int F32KE_BIT     = 6;
    localparam int OSC_FAIL_IRQ_ENABLE_BIT      = 5;
    localparam int WDOG_BIT      = 4;
    localparam int OF_BIT        = 2;
    localparam int CB_LSB        = 6;

    // ********************************
    // reset values
    // ********************************
    localparam logic [3:0] RST_SEL   = 4'h1;
    localparam logic       RST_ONE   = 1'b1;
    localparam logic       RST_ZERO  = 1'b0;

    // ********************************
    // timing
    // ********************************
    localparam int CLK_HZ      = 100_000_000;
    localparam int OSC_HZ      = 32_768;
    // half period of the fastest output in system cycles (rounded down)
    localparam int OSC_HALF_CYC = CLK_HZ / (2 * OSC_HZ);
    localparam int DIV_BITS     = 16;

endpackage

//--- rtc_board.sv
// board around the rtc auxiliary block: oscillator source and pull-ups
// assumes the bench commands oscillator start and stop through osc_on
`timescale 1ns/1ps
module rtc_board (
    // oscillator command
    input  wire logic osc_on,
    // open-drain irq pin of the block
    input  wire logic irq_out_o,
    input  wire logic irq_out_oe,
    // board side
    output logic      osc_running,
    output logic      irq_line
);
    // crystal reports alive only while commanded on
    assign osc_running = osc_on;
    // pull-up returns the released pin to high
    assign irq_line = irq_out_oe ? irq_out_o : 1'b1;
endmodule

//--- rtc_century.sv
// century bits and leap-year decision
// assumes year_rollover pulses once when the bcd year wraps 99 to 00
`timescale 1ns/1ps
module rtc_century
    import rtc_aux_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       reset_n,
    // year counter
    input  wire logic       year_rollover,
    input  wire logic [7:0] year_bcd,
    // software load
    input  wire logic       cb_wr,
    input  wire logic [1:0] cb_wdata,
    // status
    output logic [1:0]      century_q,
    output logic            leap_year
);
    logic [1:0] century_d;
    logic       div4;

    // binary count on the century turn; hardware wins over a write
    always_comb begin
        century_d = century_q;
        if (year_rollover) begin
            century_d = century_q + 2'd1;
        end else if (cb_wr) begin
            century_d = cb_wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            century_q <= 2'b00;
        end else begin
            century_q <= century_d;
        end
    end

    // bcd divisible by four: tens even with units 0,4,8 or tens odd with 2,6
    always_comb begin
        div4 = year_bcd[4] ? (year_bcd[3:0] == 4'd2 || year_bcd[3:0] == 4'd6)
                           : (year_bcd[3:0] == 4'd0 || year_bcd[3:0] == 4'd4
                              || year_bcd[3:0] == 4'd8);
        leap_year = div4 && ((year_bcd != 8'h00) || (century_q == 2'b00));
    end

    leap_a: assert property (@(posedge clk) disable iff (!reset_n)
        (year_bcd == 8'h00 && century_q != 2'b00) |-> !leap_year)
        else $error("century year marked leap");
    cent_a: assert property (@(posedge clk) disable iff (!reset_n)
        year_rollover |=> century_q == $past(century_q) + 2'd1)
        else $error("century bits did not count");
endmodule

//--- rtc_clock_div.sv
// osc divider chain producing a toggling tap per power of two
// assumes osc_tick is a one-cycle pulse at twice the oscillator rate
`timescale 1ns/1ps
module rtc_clock_div
    import rtc_aux_pkg::*;
#(
    parameter int WIDTH = DIV_BITS
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             reset_n,
    // control
    input  wire logic             run,
    input  wire logic             osc_tick,
    // taps
    output logic [WIDTH-1:0]      taps
);
    // refuse a chain too short to divide
    if (WIDTH < 2) begin : g_width_check
        $error("divider too narrow");
    end

    logic [WIDTH-1:0] cnt_q;
    logic [WIDTH-1:0] cnt_d;

    // count osc half periods; halt clears the chain to zero
    always_comb begin
        cnt_d = cnt_q;
        if (!run) begin
            cnt_d = '0;
        end else if (osc_tick) begin
            cnt_d = cnt_q + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign taps = cnt_q;
endmodule
